// ---- rtl/dpi_defs.vh ----
// constants for the ddr sdram device-side pin interface
`ifndef DPI_DEFS_VH
`define DPI_DEFS_VH

// command codes formed as {cs_n, ras_n, cas_n, we_n}
`define DPI_CMD_MRS 4'h0
`define DPI_CMD_REF 4'h1
`define DPI_CMD_PRE 4'h2
`define DPI_CMD_ACT 4'h3
`define DPI_CMD_WRITE 4'h4
`define DPI_CMD_READ 4'h5
`define DPI_CMD_BST 4'h6
`define DPI_CMD_NOP 4'h7

// power states
`define DPI_PWR_ACTIVE 2'h0
`define DPI_PWR_PRE_PD 2'h1
`define DPI_PWR_ACT_PD 2'h2
`define DPI_PWR_SELF 2'h3

// address field positions
`define DPI_AP_BIT_X32 8
`define DPI_AP_BIT_X16 10
`define DPI_ADDR_TOP 12
`define DPI_ADDR_W 13
`define DPI_COL_W 9
`define DPI_BANK_W 2
`define DPI_BANKS 4

// reset values
`define DPI_BANKS_IDLE 4'h0
`define DPI_BEATS_NONE 4'h0

`endif

// ---- rtl/dpi_pin_interface.v ----
// device-side ddr sdram pin interface: command capture, power states, data paths
`timescale 1ns/1ps
`include "dpi_defs.vh"

module dpi_pin_interface #(
  parameter DQ_WIDTH = 32,
  parameter BURST_LEN = 4
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire ck_i,
  input wire ck_n_i,
  input wire cke_i,
  input wire cs_n_i,
  input wire ras_n_i,
  input wire cas_n_i,
  input wire we_n_i,
  input wire [`DPI_BANK_W-1:0] bank_select_i,
  input wire [`DPI_ADDR_W-1:0] addr_i,
  input wire [DQ_WIDTH/8-1:0] lane_write_masks_i,
  input wire [DQ_WIDTH-1:0] dq_i,
  output wire [DQ_WIDTH-1:0] dq_o,
  output wire [DQ_WIDTH-1:0] dq_oe_o,
  input wire [DQ_WIDTH/8-1:0] lane_data_strobes_i,
  output wire [DQ_WIDTH/8-1:0] lane_data_strobes_o,
  output wire [DQ_WIDTH/8-1:0] lane_data_strobes_oe_o,
  output reg cmd_valid_o,
  output reg [3:0] cmd_code_o,
  output reg [`DPI_BANK_W-1:0] cmd_bank_o,
  output reg [`DPI_ADDR_W-1:0] cmd_row_o,
  output reg [`DPI_COL_W-1:0] cmd_col_o,
  output reg cmd_ap_o,
  output reg [`DPI_ADDR_W-1:0] mode_opcode_o,
  output wire [1:0] pwr_state_o,
  output wire [`DPI_BANKS-1:0] bank_open_o,
  output wire wr_valid_o,
  input wire wr_ready_i,
  output wire [DQ_WIDTH-1:0] wr_data_o,
  output wire [DQ_WIDTH/8-1:0] wr_be_o,
  output wire wr_overflow_o,
  input wire rd_valid_i,
  output wire rd_ready_o,
  input wire [DQ_WIDTH-1:0] rd_data_i
);

  localparam LANES = DQ_WIDTH / 8;
  localparam B = DQ_WIDTH + 2 * LANES;
  localparam SW = B + 22;

  // every pin, clock included, passes two flops before use; all share the same delay
  wire [SW-1:0] pins_w;
  reg [SW-1:0] s1_q;
  reg [SW-1:0] s2_q;
  assign pins_w = {ck_i, ck_n_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i,
                   bank_select_i, addr_i, lane_data_strobes_i, lane_write_masks_i, dq_i};

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= {SW{1'b0}};
      s2_q <= {SW{1'b0}};
    end else begin
      s1_q <= pins_w;
      s2_q <= s1_q;
    end
  end

  wire [DQ_WIDTH-1:0] dq_s = s2_q[DQ_WIDTH-1:0];
  wire [LANES-1:0] dm_s = s2_q[DQ_WIDTH +: LANES];
  wire [LANES-1:0] dqs_s = s2_q[DQ_WIDTH+LANES +: LANES];
  wire [`DPI_ADDR_W-1:0] addr_raw = s2_q[B +: `DPI_ADDR_W];
  wire [`DPI_BANK_W-1:0] ba_s = s2_q[B+13 +: `DPI_BANK_W];
  wire [3:0] code_s = s2_q[B+15 +: 4];
  wire cke_s = s2_q[B+19];
  wire cross_hi = s2_q[B+21] & ~s2_q[B+20];

  // x32 has no use for the top address line
  wire [`DPI_ADDR_W-1:0] addr_s;
  assign addr_s = (DQ_WIDTH == 32) ? {1'b0, addr_raw[`DPI_ADDR_TOP-1:0]} : addr_raw;

  function [`DPI_COL_W-1:0] col_of;
    input [`DPI_ADDR_W-1:0] a;
    begin
      if (DQ_WIDTH == 32)
        col_of = {a[9], a[7:0]};
      else
        col_of = a[`DPI_COL_W-1:0];
    end
  endfunction

  function ap_of;
    input [`DPI_ADDR_W-1:0] a;
    begin
      if (DQ_WIDTH == 32)
        ap_of = a[`DPI_AP_BIT_X32];
      else
        ap_of = a[`DPI_AP_BIT_X16];
    end
  endfunction

  reg cross_hi_q;
  reg [LANES-1:0] dqs_q;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cross_hi_q <= 1'b0;
      dqs_q <= {LANES{1'b0}};
    end else begin
      cross_hi_q <= cross_hi;
      dqs_q <= dqs_s;
    end
  end

  wire ck_rise = cross_hi & ~cross_hi_q;
  wire ck_fall = ~cross_hi & cross_hi_q;

  reg [1:0] pwr_q;
  reg [`DPI_BANKS-1:0] open_q;
  wire awake = (pwr_q == `DPI_PWR_ACTIVE);
  assign pwr_state_o = pwr_q;
  assign bank_open_o = open_q;

  // commands taken on a link clock rise while awake, whatever the gate; chip select is part of the code
  wire take = ck_rise & awake & ~code_s[3];
  wire is_cmd_ref = take & (code_s == `DPI_CMD_REF);

  reg [3:0] wr_left_q;
  reg [3:0] rd_left_q;
  reg wr_ap_q;
  reg rd_ap_q;
  reg [`DPI_BANK_W-1:0] wr_bank_q;
  reg [`DPI_BANK_W-1:0] rd_bank_q;
  wire wr_push;
  wire rd_beat = (ck_rise | ck_fall) & (rd_left_q != `DPI_BEATS_NONE) & awake;
  wire wr_last = wr_push & (wr_left_q == 4'h1);
  wire rd_last = rd_beat & (rd_left_q == 4'h1);

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_q <= `DPI_PWR_ACTIVE;
    end else begin
      case (pwr_q)
        `DPI_PWR_ACTIVE: begin
          if (ck_rise && !cke_s) begin
            if (is_cmd_ref && open_q == `DPI_BANKS_IDLE)
              pwr_q <= `DPI_PWR_SELF;
            else if (open_q != `DPI_BANKS_IDLE)
              pwr_q <= `DPI_PWR_ACT_PD;
            else
              pwr_q <= `DPI_PWR_PRE_PD;
          end
        end
        `DPI_PWR_PRE_PD, `DPI_PWR_ACT_PD: begin
          if (ck_rise && cke_s)
            pwr_q <= `DPI_PWR_ACTIVE;
        end
        `DPI_PWR_SELF: begin
          // the clock may be stopped here, so exit does not wait for a clock edge
          if (cke_s)
            pwr_q <= `DPI_PWR_ACTIVE;
        end
        default: pwr_q <= `DPI_PWR_ACTIVE;
      endcase
    end
  end

  // command decode and bank tracking
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_code_o <= `DPI_CMD_NOP;
      cmd_bank_o <= {`DPI_BANK_W{1'b0}};
      cmd_row_o <= {`DPI_ADDR_W{1'b0}};
      cmd_col_o <= {`DPI_COL_W{1'b0}};
      cmd_ap_o <= 1'b0;
      mode_opcode_o <= {`DPI_ADDR_W{1'b0}};
      open_q <= `DPI_BANKS_IDLE;
      wr_left_q <= `DPI_BEATS_NONE;
      rd_left_q <= `DPI_BEATS_NONE;
      wr_ap_q <= 1'b0;
      rd_ap_q <= 1'b0;
      wr_bank_q <= {`DPI_BANK_W{1'b0}};
      rd_bank_q <= {`DPI_BANK_W{1'b0}};
    end else begin
      cmd_valid_o <= take & (code_s != `DPI_CMD_NOP) & (cke_s | is_cmd_ref);
      if (wr_push)
        wr_left_q <= wr_left_q - 4'h1;
      if (rd_beat)
        rd_left_q <= rd_left_q - 4'h1;
      if (wr_last && wr_ap_q)
        open_q[wr_bank_q] <= 1'b0;
      if (rd_last && rd_ap_q)
        open_q[rd_bank_q] <= 1'b0;
      if (take) begin
        cmd_code_o <= code_s;
        cmd_bank_o <= ba_s;
        cmd_ap_o <= ap_of(addr_s);
        case (code_s)
          `DPI_CMD_ACT: begin
            cmd_row_o <= addr_s;
            open_q[ba_s] <= 1'b1;
          end
          `DPI_CMD_READ: begin
            cmd_col_o <= col_of(addr_s);
            rd_left_q <= BURST_LEN[3:0];
            rd_ap_q <= ap_of(addr_s);
            rd_bank_q <= ba_s;
          end
          `DPI_CMD_WRITE: begin
            cmd_col_o <= col_of(addr_s);
            wr_left_q <= BURST_LEN[3:0];
            wr_ap_q <= ap_of(addr_s);
            wr_bank_q <= ba_s;
          end
          `DPI_CMD_PRE: begin
            if (ap_of(addr_s))
              open_q <= `DPI_BANKS_IDLE;
            else
              open_q[ba_s] <= 1'b0;
          end
          `DPI_CMD_BST: rd_left_q <= `DPI_BEATS_NONE;
          `DPI_CMD_MRS: mode_opcode_o <= addr_s;
          default: cmd_ap_o <= ap_of(addr_s);
        endcase
      end
    end
  end

  // write capture: each lane takes its byte and mask on its own strobe edge
  reg [DQ_WIDTH-1:0] word_q;
  reg [LANES-1:0] be_q;
  reg [LANES-1:0] got_q;
  reg ovf_q;
  wire in_ready;
  wire wr_active = (wr_left_q != `DPI_BEATS_NONE) & awake;
  assign wr_push = wr_active & (&got_q);
  assign wr_overflow_o = ovf_q;
  integer l;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_q <= {DQ_WIDTH{1'b0}};
      be_q <= {LANES{1'b0}};
      got_q <= {LANES{1'b0}};
      ovf_q <= 1'b0;
    end else begin
      if (wr_push && !in_ready)
        ovf_q <= 1'b1;
      for (l = 0; l < LANES; l = l + 1) begin
        if (wr_active && (dqs_s[l] ^ dqs_q[l]) && !got_q[l]) begin
          word_q[l*8 +: 8] <= dq_s[l*8 +: 8];
          be_q[l] <= ~dm_s[l];
          got_q[l] <= 1'b1;
        end else if (wr_push || !wr_active) begin
          got_q[l] <= 1'b0;
        end
      end
    end
  end

  // two-entry buffer; a pin burst cannot be paused, so a full buffer drops the word
  reg [DQ_WIDTH-1:0] buf_d_q [0:1];
  reg [LANES-1:0] buf_be_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire do_in = wr_push & in_ready;
  wire do_out = wr_valid_o & wr_ready_i;
  assign in_ready = (cnt_q != 2'h2);
  assign wr_valid_o = (cnt_q != 2'h0);
  assign wr_data_o = buf_d_q[rp_q];
  assign wr_be_o = buf_be_q[rp_q];

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      buf_d_q[0] <= {DQ_WIDTH{1'b0}};
      buf_d_q[1] <= {DQ_WIDTH{1'b0}};
      buf_be_q[0] <= {LANES{1'b0}};
      buf_be_q[1] <= {LANES{1'b0}};
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (do_in) begin
        buf_d_q[wp_q] <= word_q;
        buf_be_q[wp_q] <= be_q;
        wp_q <= ~wp_q;
      end
      if (do_out)
        rp_q <= ~rp_q;
      if (do_in && !do_out)
        cnt_q <= cnt_q + 2'h1;
      else if (do_out && !do_in)
        cnt_q <= cnt_q - 2'h1;
    end
  end

  // read drive: strobe toggles with each beat so edges line up with data
  reg [DQ_WIDTH-1:0] dq_out_q;
  reg dqs_out_q;
  reg drive_q;
  assign rd_ready_o = rd_beat;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dq_out_q <= {DQ_WIDTH{1'b0}};
      dqs_out_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      if (take && code_s == `DPI_CMD_READ) begin
        drive_q <= 1'b1;
        dqs_out_q <= 1'b0;
      end else if (rd_beat) begin
        dq_out_q <= rd_valid_i ? rd_data_i : {DQ_WIDTH{1'b0}};
        dqs_out_q <= ~dqs_out_q;
      end else if ((ck_rise || ck_fall) && rd_left_q == `DPI_BEATS_NONE) begin
        drive_q <= 1'b0;
      end
    end
  end

  wire drv = drive_q & awake;
  assign dq_o = dq_out_q;
  assign dq_oe_o = {DQ_WIDTH{drv}};
  assign lane_data_strobes_o = {LANES{dqs_out_q}};
  assign lane_data_strobes_oe_o = {LANES{drv}};

endmodule

// ---- verif/dpi_pin_interface_chk.sv ----
// port assertions for the ddr pin interface
`timescale 1ns/1ps
`include "dpi_defs.vh"
module dpi_pin_interface_chk #(
  parameter DQ_WIDTH = 32
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire cke_i,
  input wire rd_valid_i,
  input wire [DQ_WIDTH-1:0] rd_data_i,
  input wire rd_ready_o,
  input wire [DQ_WIDTH-1:0] dq_o,
  input wire [DQ_WIDTH-1:0] dq_oe_o,
  input wire [DQ_WIDTH/8-1:0] lane_data_strobes_oe_o,
  input wire cmd_valid_o,
  input wire [3:0] cmd_code_o,
  input wire [1:0] pwr_state_o,
  input wire wr_valid_o,
  input wire wr_ready_i,
  input wire [DQ_WIDTH-1:0] wr_data_o,
  input wire [DQ_WIDTH/8-1:0] wr_be_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // four cycles covers the two sync flops and the state update
  sequence s_gate_up;
    cke_i [*4];
  endsequence
  sequence s_beat;
    rd_ready_o && rd_valid_i;
  endsequence
  a_oe_lanes_equal: assert property (dq_oe_o == {DQ_WIDTH{dq_oe_o[0]}})
    else $error("data enables differ");
  a_strobe_oe_match: assert property (lane_data_strobes_oe_o == {DQ_WIDTH/8{dq_oe_o[0]}})
    else $error("strobe enable differs from data enable");
  a_drive_when_active: assert property (dq_oe_o[0] |-> pwr_state_o == `DPI_PWR_ACTIVE)
    else $error("drivers on in low power");
  a_beat_loads_pin: assert property (s_beat |=> dq_o == $past(rd_data_i))
    else $error("read word not loaded");
  a_beat_zero_fill: assert property (rd_ready_o && !rd_valid_i |=> dq_o == '0)
    else $error("idle read word not zero");
  a_cmd_one_pulse: assert property (cmd_valid_o |=> !cmd_valid_o [*8])
    else $error("command pulse repeated");
  a_cmd_selected: assert property (cmd_valid_o |-> !cmd_code_o[3] && cmd_code_o != `DPI_CMD_NOP)
    else $error("deselected or idle command taken");
  a_wr_word_hold: assert property (wr_valid_o && !wr_ready_i |=>
    wr_valid_o && $stable(wr_data_o) && $stable(wr_be_o))
    else $error("stalled write word changed");
  a_self_ref_exit: assert property (s_gate_up |=> pwr_state_o != `DPI_PWR_SELF)
    else $error("self refresh held with gate high");
endmodule

bind dpi_pin_interface dpi_pin_interface_chk #(.DQ_WIDTH(DQ_WIDTH)) u_chk (.*);

// ---- verif/dpi_ctrl_model.sv ----
// controller model: link clock, command pins and write beats
`timescale 1ns/1ps
module dpi_ctrl_model (
  input wire clk_i,
  output reg ck_o,
  output reg ck_n_o,
  output reg cke_o,
  output reg [3:0] cmd_o,
  output reg [1:0] bank_o,
  output reg [12:0] addr_o,
  output reg [3:0] mask_o,
  output reg [31:0] dq_o,
  output reg [3:0] dqs_o
);
  initial begin
    {ck_o, dqs_o, mask_o, dq_o, bank_o, addr_o} = '0;
    {ck_n_o, cke_o} = 2'h3;
    cmd_o = 4'hF;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // link clock runs only while a command or burst is under way
  task automatic cmd(input [3:0] c, input [1:0] b, input [12:0] a, input k, input int n);
    @(posedge clk_i);
    cmd_o <= c;
    bank_o <= b;
    addr_o <= a;
    cke_o <= k;
    tick(3);
    for (int i = 0; i < n; i++) begin
      ck_o <= ~ck_o;
      ck_n_o <= ck_o;
      if (i == 1) begin
        cmd_o <= 4'hF;
        bank_o <= ~b;
        addr_o <= ~a;
      end
      tick(10);
    end
  endtask
  // strobe parks at its level: an inverted idle would read as a beat
  task automatic wr(input [127:0] d, input [15:0] m);
    for (int i = 0; i < 4; i++) begin
      dq_o <= d[32*i+:32];
      mask_o <= m[4*i+:4];
      tick(2);
      dqs_o <= ~dqs_o;
      tick(4);
    end
    dq_o <= ~dq_o;
    mask_o <= ~mask_o;
  endtask
  task automatic gate(input k);
    @(posedge clk_i);
    cke_o <= k;
  endtask
endmodule

// ---- verif/ddr_sdram_pin_interface_test.sv ----
// self-checking bench for the ddr pin interface
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module ddr_sdram_pin_interface_test;
  reg clk_i, arst_n_i, wr_ready_i, rd_valid_i;
  reg [31:0] rd_data_i;
  wire ck, ck_n, cke, cmd_valid_o, cmd_ap_o, wr_valid_o, wr_overflow_o, rd_ready_o;
  wire [3:0] cmd, msk, dqs_m, dqs_w, lane_data_strobes_o, lane_data_strobes_oe_o;
  wire [3:0] wr_be_o, cmd_code_o, bank_open_o;
  wire [1:0] ba, pwr_state_o, cmd_bank_o;
  wire [12:0] a_p, cmd_row_o, mode_opcode_o;
  wire [31:0] dq_m, dq_w, dq_o, dq_oe_o, wr_data_o;
  wire [8:0] cmd_col_o;
  int errors, checks_done, seed, npulse, n0, k, i;
  reg [12:0] a;
  reg [1:0] b;
  reg [127:0] d;
  reg [15:0] mk;
  reg [1:0] rd_d;
  reg [1:0] rdy_mode;
  reg [35:0] wq[$];
  reg [31:0] rq[$];
  // {code, gate, expected power state}
  reg [6:0] tab [8] = '{7'h3A, 7'h3C, 7'h14, 7'h39, 7'h19, 7'h3C, 7'h0C, 7'h0B};
  assign dq_w = dq_oe_o[0] ? dq_o : dq_m;
  assign dqs_w = lane_data_strobes_oe_o[0] ? lane_data_strobes_o : dqs_m;
  dpi_pin_interface #(.DQ_WIDTH(32), .BURST_LEN(4)) uut (.clk_i, .arst_n_i, .ck_i(ck),
    .ck_n_i(ck_n), .cke_i(cke), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]),
    .we_n_i(cmd[0]), .bank_select_i(ba), .addr_i(a_p), .lane_write_masks_i(msk),
    .dq_i(dq_w), .dq_o, .dq_oe_o, .lane_data_strobes_i(dqs_w), .lane_data_strobes_o,
    .lane_data_strobes_oe_o, .cmd_valid_o, .cmd_code_o, .cmd_bank_o, .cmd_row_o, .cmd_col_o,
    .cmd_ap_o, .mode_opcode_o, .pwr_state_o, .bank_open_o, .wr_valid_o, .wr_ready_i,
    .wr_data_o, .wr_be_o, .wr_overflow_o, .rd_valid_i, .rd_ready_o, .rd_data_i);
  dpi_ctrl_model m (.clk_i, .ck_o(ck), .ck_n_o(ck_n), .cke_o(cke), .cmd_o(cmd), .bank_o(ba),
    .addr_o(a_p), .mask_o(msk), .dq_o(dq_m), .dqs_o(dqs_m));
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (cmd_valid_o === 1'b1) npulse++;
    if (wr_valid_o === 1'b1 && wr_ready_i) wq.push_back({wr_data_o, wr_be_o});
    rd_d <= {rd_d[0], rd_ready_o === 1'b1};
    // mode 0 stalls, 1 stalls at random, 2 always ready
    wr_ready_i <= rdy_mode[1] || (rdy_mode[0] && ($random(seed) % 4) != 0);
    if (rd_d[1]) `CHK("read pin", rq[$], dq_w)
    if (rd_d[1]) `CHK("read strobe", {4{rq.size() % 2 == 1}}, dqs_w)
    if (rd_ready_o === 1'b1) begin
      rq.push_back(rd_valid_i ? rd_data_i : 32'h0);
      rd_data_i <= $random(seed);
      rd_valid_i <= ($random(seed) % 4) != 0;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // about ten times the expected run
  initial begin
    #60000;
    errors++;
    report_and_stop();
  end
  initial begin
    {arst_n_i, wr_ready_i, rd_valid_i, rd_data_i, rd_d, rdy_mode} = '0;
    {errors, checks_done, npulse} = '0;
    seed = 45;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1;
    m.tick(4);
    b = 2'($random(seed));
    a = 13'($random(seed)) | 13'h1000;
    n0 = npulse;
    m.cmd(4'h3, b, a, 1, 2);
    `CHK("pulses", n0 + 1, npulse)
    `CHK("code", 4'h3, cmd_code_o)
    `CHK("bank", b, cmd_bank_o)
    `CHK("row", {1'b0, a[11:0]}, cmd_row_o)
    `CHK("open", 4'h1 << b, bank_open_o)
    n0 = npulse;
    m.cmd(4'hC, ~b, a, 1, 2);
    `CHK("pulses", n0, npulse)
    a = 13'($random(seed)) & 13'h0FFF;
    m.cmd(4'h0, 2'h0, a, 1, 2);
    `CHK("opcode", a, mode_opcode_o)
    $display("commands done");
    for (k = 0; k < 2; k++) begin
      m.cmd(4'h3, b, a, 1, 2);
      wq.delete();
      rdy_mode <= {1'b0, k[0]};
      a = 13'($random(seed)) & 13'h0EFF | (k ? 13'h0000 : 13'h0100);
      d = {$random(seed), $random(seed), $random(seed), $random(seed)};
      mk = 16'($random(seed));
      m.cmd(4'h4, b, a, 1, 2);
      m.wr(d, mk);
      m.tick(10);
      rdy_mode <= 2'h2;
      m.tick(6);
      `CHK("column", {a[9], a[7:0]}, cmd_col_o)
      `CHK("precharge bit", ~k[0], cmd_ap_o)
      `CHK("words", k ? 4 : 2, wq.size())
      for (i = 0; i < wq.size(); i++) `CHK("word", {d[32*i+:32], ~mk[4*i+:4]}, wq[i])
      `CHK("open", k[0], bank_open_o[b])
    end
    `CHK("overflow", 1'b1, wr_overflow_o)
    $display("writes done");
    rd_valid_i <= 1;
    rd_data_i <= $random(seed);
    rq.delete();
    m.cmd(4'h5, b, a, 1, 10);
    `CHK("beats", 4, rq.size())
    `CHK("data enable", 32'h0, dq_oe_o)
    $display("read done");
    for (i = 0; i < 8; i++) begin
      m.cmd(tab[i][6:3], b, a | 13'h0100, tab[i][2], 2);
      `CHK("power state", tab[i][1:0], pwr_state_o)
    end
    `CHK("banks", 4'h0, bank_open_o)
    m.gate(1);
    m.tick(6);
    `CHK("power state", 2'h0, pwr_state_o)
    $display("power done");
    // two open banks, one closed by a single-bank precharge
    m.cmd(4'h3, ~b, a, 1, 2);
    m.cmd(4'h3, b, a, 1, 2);
    m.cmd(4'h2, ~b, a, 1, 2);
    `CHK("open", 4'h1 << b, bank_open_o)
    // burst stop cuts the read after its second beat
    rq.delete();
    m.cmd(4'h5, b, a, 1, 2);
    m.cmd(4'h6, b, a, 1, 2);
    `CHK("beats", 2, rq.size())
    `CHK("data enable", 32'h0, dq_oe_o)
    $display("bank and burst stop done");
    report_and_stop();
  end
endmodule
